// *** rtl/qdtr_channel_regs.v ***
// Per-channel code, range and trim registers with load-to-converter path
//
// How it works
// - select 010 writes the channel data register
// - data write takes all sixteen payload bits
// - channel address picks the updated channel
// - select 011 writes the output range register
// - range is two bits from payload bits 1:0
// - range 00 default, 01 and 10 wider spans
// - select 100 writes the fine gain trim
// - gain trim is six low payload bits
// - gain step moves both full-scale points together
// - gain trim is two's complement, zero default
// - select 101 writes the offset trim
// - offset trim is eight low payload bits
// - offset trim is two's complement, zero default
// - channel codes 0-3 single, 4 all channels
// - data reaches converters only on load function
`include "qdtr_defs.vh"

module qdtr_channel_regs (
    input wire clk_sys,
    input wire rstn,
    input wire [`QDTR_WORD_W-1:0] word, // Complete write word from the serial shifter
    input wire word_valid, // One-cycle strobe, word is complete
    output reg [`QDTR_NUM_CH*`QDTR_CODE_W-1:0] channel_input_code, // Input codes, channel A in low bits
    output reg [`QDTR_NUM_CH*`QDTR_CODE_W-1:0] converter_code, // Codes driving the converters
    output reg [`QDTR_NUM_CH*`QDTR_RANGE_W-1:0] channel_output_range, // Range selection per channel
    output reg [`QDTR_NUM_CH*`QDTR_GAIN_W-1:0] channel_gain_trim, // Fine gain trim per channel
    output reg [`QDTR_NUM_CH*`QDTR_OFFS_W-1:0] channel_offset_trim, // Offset trim per channel
    output reg converter_update // One-cycle pulse while converter codes show a fresh load
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire [`QDTR_NUM_CH-1:0] wr_code; // Data register strobes
    wire [`QDTR_NUM_CH-1:0] wr_range; // Range register strobes
    wire [`QDTR_NUM_CH-1:0] wr_gain; // Gain trim strobes
    wire [`QDTR_NUM_CH-1:0] wr_offs; // Offset trim strobes
    wire load_all; // Load function seen

    // Payload fields
    wire [`QDTR_CODE_W-1:0] word_payload; // Full data payload
    wire range_code_hi; // Range selection upper bit
    wire range_code_lo; // Range selection lower bit
    wire [`QDTR_RANGE_W-1:0] range_code; // Range selection field
    wire [`QDTR_GAIN_W-1:0] gain_field; // Gain trim field
    wire [`QDTR_OFFS_W-1:0] offs_field; // Offset trim field

    assign word_payload = word[`QDTR_PAY_HI:`QDTR_PAY_LO];
    assign range_code_hi = word[`QDTR_RANGE_W-1];
    assign range_code_lo = word[`QDTR_PAY_LO];
    assign range_code = {range_code_hi, range_code_lo};
    assign gain_field = word[`QDTR_GAIN_W-1:0];
    assign offs_field = word[`QDTR_OFFS_W-1:0];

    qdtr_word_decode u_decode (
        .word(word),
        .word_valid(word_valid),
        .wr_code(wr_code),
        .wr_range(wr_range),
        .wr_gain(wr_gain),
        .wr_offs(wr_offs),
        .load_all(load_all)
    );

    // ----------------------------------------------------------------
    // Per-channel storage
    // ----------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < `QDTR_NUM_CH; ch = ch + 1) begin : g_ch
            // Input code register, held until the load function
            always @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    channel_input_code[ch*`QDTR_CODE_W +: `QDTR_CODE_W] <= `QDTR_CODE_RST;
                end else if (wr_code[ch]) begin
                    channel_input_code[ch*`QDTR_CODE_W +: `QDTR_CODE_W] <= word_payload;
                end
            end

            // Converter register, copied only on load
            always @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    converter_code[ch*`QDTR_CODE_W +: `QDTR_CODE_W] <= `QDTR_CODE_RST;
                end else if (load_all) begin
                    converter_code[ch*`QDTR_CODE_W +: `QDTR_CODE_W] <=
                        channel_input_code[ch*`QDTR_CODE_W +: `QDTR_CODE_W];
                end
            end

            // Range register; the undefined code keeps the old value
            always @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    channel_output_range[ch*`QDTR_RANGE_W +: `QDTR_RANGE_W] <= `QDTR_RANGE_10V;
                end else if (wr_range[ch] && (range_code != `QDTR_RANGE_BAD)) begin
                    channel_output_range[ch*`QDTR_RANGE_W +: `QDTR_RANGE_W] <= range_code;
                end
            end

            // Gain trim, stored as signed code for the analog core
            always @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    channel_gain_trim[ch*`QDTR_GAIN_W +: `QDTR_GAIN_W] <= `QDTR_GAIN_RST;
                end else if (wr_gain[ch]) begin
                    // Core applies half a step at each full-scale end
                    channel_gain_trim[ch*`QDTR_GAIN_W +: `QDTR_GAIN_W] <= gain_field;
                end
            end

            // Offset trim, signed eighth-step code
            always @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    channel_offset_trim[ch*`QDTR_OFFS_W +: `QDTR_OFFS_W] <= `QDTR_OFFS_RST;
                end else if (wr_offs[ch]) begin
                    channel_offset_trim[ch*`QDTR_OFFS_W +: `QDTR_OFFS_W] <= offs_field;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Update pulse
    // ----------------------------------------------------------------
    // Marks the cycle in which converter codes have just changed
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            converter_update <= 1'h0;
        end else begin
            converter_update <= load_all;
        end
    end
endmodule // qdtr_channel_regs

// *** rtl/qdtr_defs.vh ***
// Constants for the quad converter channel trim register block
`ifndef QDTR_DEFS_VH
`define QDTR_DEFS_VH

// Write word layout
`define QDTR_WORD_W 24
`define QDTR_TGT_HI 21
`define QDTR_TGT_LO 19
`define QDTR_CH_HI 18
`define QDTR_CH_LO 16
`define QDTR_PAY_HI 15
`define QDTR_PAY_LO 0

// Register-select codes
`define QDTR_TGT_FUNC 3'h0
`define QDTR_TGT_DATA 3'h2
`define QDTR_TGT_RANGE 3'h3
`define QDTR_TGT_GAIN 3'h4
`define QDTR_TGT_OFFS 3'h5

// Function-register sub-codes used here
`define QDTR_FUNC_LOAD 3'h5

// Channel-address codes
`define QDTR_CH_ALL 3'h4
`define QDTR_NUM_CH 4

// Field widths
`define QDTR_CODE_W 16
`define QDTR_RANGE_W 2
`define QDTR_GAIN_W 6
`define QDTR_OFFS_W 8

// Range codes
`define QDTR_RANGE_10V 2'h0
`define QDTR_RANGE_10V26 2'h1
`define QDTR_RANGE_10V53 2'h2
`define QDTR_RANGE_BAD 2'h3

// Reset values
`define QDTR_CODE_RST 16'h0000
`define QDTR_GAIN_RST 6'h00
`define QDTR_OFFS_RST 8'h00

`endif

// *** rtl/qdtr_word_decode.v ***
// Decoder that splits one write word into per-channel update strobes
`include "qdtr_defs.vh"

module qdtr_word_decode (
    input wire [`QDTR_WORD_W-1:0] word,
    input wire word_valid,
    output reg [`QDTR_NUM_CH-1:0] wr_code,
    output reg [`QDTR_NUM_CH-1:0] wr_range,
    output reg [`QDTR_NUM_CH-1:0] wr_gain,
    output reg [`QDTR_NUM_CH-1:0] wr_offs,
    output reg load_all
);
    // ----------------------------------------------------------------
    // Field extraction
    // ----------------------------------------------------------------
    wire [2:0] target_select; // Register-select field
    wire [2:0] channel_sel; // Channel-address field
    reg [`QDTR_NUM_CH-1:0] ch_mask; // Channels hit by this word

    assign target_select = word[`QDTR_TGT_HI:`QDTR_TGT_LO];
    assign channel_sel = word[`QDTR_CH_HI:`QDTR_CH_LO];

    // ----------------------------------------------------------------
    // Channel and target decode
    // ----------------------------------------------------------------
    // Turns the channel address into a one-hot or all-ones mask
    always @* begin
        ch_mask = {`QDTR_NUM_CH{1'h0}};
        if (channel_sel == `QDTR_CH_ALL) begin
            ch_mask = {`QDTR_NUM_CH{1'h1}};
        end else if (channel_sel < `QDTR_CH_ALL) begin
            ch_mask[channel_sel[1:0]] = 1'h1;
        end
        // Other channel codes leave the mask empty
    end

    // Routes the mask to the strobes of the addressed register
    always @* begin
        wr_code = {`QDTR_NUM_CH{1'h0}};
        wr_range = {`QDTR_NUM_CH{1'h0}};
        wr_gain = {`QDTR_NUM_CH{1'h0}};
        wr_offs = {`QDTR_NUM_CH{1'h0}};
        load_all = 1'h0;
        if (word_valid) begin
            case (target_select)
                `QDTR_TGT_DATA: wr_code = ch_mask;
                `QDTR_TGT_RANGE: wr_range = ch_mask;
                `QDTR_TGT_GAIN: wr_gain = ch_mask;
                `QDTR_TGT_OFFS: wr_offs = ch_mask;
                `QDTR_TGT_FUNC: load_all = (channel_sel == `QDTR_FUNC_LOAD);
                default: load_all = 1'h0; // Undefined targets ignored
            endcase
        end
    end
endmodule // qdtr_word_decode

// *** tb/qdtr_channel_regs_sva.sv ***
// Concurrent checks on the ports of the channel trim register block
`include "qdtr_defs.vh"
module qdtr_channel_regs_sva (
    input wire clk_sys,
    input wire rstn,
    input wire [23:0] word,
    input wire word_valid,
    input wire [63:0] channel_input_code,
    input wire [63:0] converter_code,
    input wire [7:0] channel_output_range,
    input wire [23:0] channel_gain_trim,
    input wire [31:0] channel_offset_trim,
    input wire converter_update
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire [5:0] hd = word[21:16]; // Select and channel fields together
    wire ld = word_valid && hd == 6'h05; // Load function taken
    data_write_a: assert property (
        word_valid && hd == 6'h10 |=> channel_input_code[15:0] == $past(word[15:0]))
        else $error("data write to channel A lost");
    range_write_a: assert property (
        word_valid && hd == 6'h1B && word[1:0] != 2'h3 |=> channel_output_range[7:6] == $past(word[1:0]))
        else $error("range write lost");
    gain_write_a: assert property (
        word_valid && hd == 6'h22 |=> channel_gain_trim[17:12] == $past(word[5:0]))
        else $error("gain trim write lost");
    offset_write_a: assert property (
        word_valid && hd == 6'h29 |=> channel_offset_trim[15:8] == $past(word[7:0]))
        else $error("offset trim write lost");
    all_channels_a: assert property (
        word_valid && hd == 6'h24 |=> channel_gain_trim == {4{$past(word[5:0])}})
        else $error("broadcast gain write wrong");
    load_copy_a: assert property (
        ld |=> converter_update && converter_code == $past(channel_input_code))
        else $error("load did not copy codes");
    update_cause_a: assert property (
        !ld |=> !converter_update && $stable(converter_code))
        else $error("converter changed without load");
    bad_range_a: assert property (
        word_valid && word[21:19] == 3'h3 && word[1:0] == 2'h3 |=> $stable(channel_output_range))
        else $error("range code 11 accepted");
    undefined_sel_a: assert property (
        word_valid && (word[21:19] == 3'h1 || word[21:19] > 3'h5)
        |=> $stable({channel_input_code, channel_output_range, channel_gain_trim, channel_offset_trim}))
        else $error("undefined select changed state");
    undefined_chan_a: assert property (
        word_valid && word[21:19] >= 3'h2 && word[21:19] <= 3'h5 && word[18:16] > 3'h4
        |=> $stable({channel_input_code, channel_output_range, channel_gain_trim, channel_offset_trim}))
        else $error("undefined channel changed state");
    cover property (ld);
    cover property (word_valid && hd == 6'h24);
    cover property (word_valid && word[21:19] == 3'h3 && word[1:0] == 2'h3);
endmodule // qdtr_channel_regs_sva
bind qdtr_channel_regs qdtr_channel_regs_sva qdtr_channel_regs_sva_i (.clk_sys(clk_sys), .rstn(rstn), .word(word),
    .word_valid(word_valid), .channel_input_code(channel_input_code), .converter_code(converter_code),
    .channel_output_range(channel_output_range), .channel_gain_trim(channel_gain_trim),
    .channel_offset_trim(channel_offset_trim), .converter_update(converter_update));

// *** tb/qdtr_host_model.sv ***
// Host model that issues whole write words to the trim registers
module qdtr_host_model (
    input wire clk_sys,
    output logic [23:0] word,
    output logic word_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        word = 24'h000000;
        word_valid = 1'h0;
    end
    // Present one whole word for one taking edge; caller picks the select code
    task automatic send(input logic [23:0] w);
        @(posedge clk_sys);
        word <= w;
        word_valid <= 1'h1;
    endtask
    // Drop the strobe and scramble the stale word so it cannot pass for valid
    task automatic idle();
        @(posedge clk_sys);
        word_valid <= 1'h0;
        word <= ~word;
    endtask
endmodule // qdtr_host_model

// *** tb/quad_dac_channel_trim_registers_bench.sv ***
// Self-checking bench for the channel trim register block
module quad_dac_channel_trim_registers_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [192:0] qdtr_snap_t; // Expected outputs and update flag
    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    logic took = 1'h0; // Previous edge took a word
    wire [23:0] word;
    wire word_valid;
    wire [63:0] code, conv;
    wire [7:0] rng;
    wire [23:0] gain;
    wire [31:0] offs;
    wire upd;
    logic [63:0] e_in = '0, e_cv = '0; // Expected input and converter codes
    logic [7:0] e_rg = '0;
    logic [23:0] e_gn = '0;
    logic [31:0] e_of = '0;
    qdtr_snap_t notes[$]; // Notes awaiting their result
    integer n_fail = 0, n_tests = 0, seed = 32'h09f3, k;
    qdtr_host_model qdtr_host_model_i (.clk_sys(clk_sys), .word(word), .word_valid(word_valid));
    qdtr_channel_regs qdtr_channel_regs_i (.clk_sys(clk_sys), .rstn(rstn), .word(word), .word_valid(word_valid),
        .channel_input_code(code), .converter_code(conv), .channel_output_range(rng),
        .channel_gain_trim(gain), .channel_offset_trim(offs), .converter_update(upd));
    initial forever #10 clk_sys = ~clk_sys;
    // Compare every output against one note
    task automatic chk(input qdtr_snap_t e);
        n_tests++;
        if ({code, conv, rng, gain, offs, upd} !== e) begin
            n_fail++;
            $display("ERROR %0t outputs differ from expected", $time);
        end
    endtask
    // Update the channel model, note the result, then send the word
    task automatic wr(input logic [2:0] s, input logic [2:0] c, input logic [15:0] p);
        logic u;
        u = (s == 3'h0 && c == 3'h5);
        for (int i = 0; i < 4; i++) begin
            if (c == i || c == 3'h4) begin
                if (s == 3'h2) e_in[i*16 +: 16] = p;
                if (s == 3'h3 && p[1:0] != 2'h3) e_rg[i*2 +: 2] = p[1:0];
                if (s == 3'h4) e_gn[i*6 +: 6] = p[5:0];
                if (s == 3'h5) e_of[i*8 +: 8] = p[7:0];
            end
        end
        if (u) e_cv = e_in;
        notes.push_back({e_in, e_cv, e_rg, e_gn, e_of, u});
        qdtr_host_model_i.send({2'($random(seed)), s, c, p});
    endtask
    task conclude;
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Results land at the edge that takes the word; look at the next falling edge
    always @(posedge clk_sys) took <= word_valid && rstn;
    always @(negedge clk_sys) begin
        if (took) chk(notes.pop_front());
    end
    initial begin
        #100000;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'h1;
        @(negedge clk_sys);
        chk('0);
        wr(3'h2, 3'h0, 16'hA5C3);
        wr(3'h3, 3'h3, 16'hFFFE);
        wr(3'h4, 3'h2, 16'hFFE0);
        wr(3'h5, 3'h1, 16'hFF80);
        wr(3'h4, 3'h4, 16'h001F);
        wr(3'h3, 3'h0, 16'h0003);
        wr(3'h0, 3'h5, 16'h1234);
        wr(3'h1, 3'h0, 16'hFFFF);
        wr(3'h2, 3'h6, 16'h5555);
        for (k = 0; k < 80; k++) begin
            wr(3'($random(seed)), 3'($random(seed)), 16'($random(seed)));
            if (k % 8 == 7) wr(3'h0, 3'h5, 16'($random(seed)));
            if ($random(seed) & 1) qdtr_host_model_i.idle();
        end
        qdtr_host_model_i.idle();
        repeat (2) @(posedge clk_sys);
        rstn <= 1'h0;
        {e_in, e_cv, e_rg, e_gn, e_of} = '0;
        @(posedge clk_sys);
        rstn <= 1'h1;
        @(negedge clk_sys);
        chk('0);
        wr(3'h2, 3'h4, 16'h8001);
        wr(3'h0, 3'h5, 16'h0000);
        qdtr_host_model_i.idle();
        repeat (3) @(posedge clk_sys);
        conclude();
    end
endmodule // quad_dac_channel_trim_registers_bench
